/* File: src/protected_page_remove_and_track.sv */
// Page removal and tracking start engine behind an APB register file
`timescale 1ns/10ps

module protected_page_remove_and_track
  import page_mgmt_pkg::*;
#(
  parameter int unsigned         PAGES                = 16,
  parameter logic [31:0]         CACHE_BASE           = page_mgmt_pkg::cache_base_default,
  parameter logic [31:0]         CHILD_PRESENT_CODE   = page_mgmt_pkg::child_present_code_default,
  parameter logic [31:0]         ENCLAVE_ACTIVE_CODE  = page_mgmt_pkg::enclave_active_code_default,
  parameter logic [15:0]         CONFLICT_EXIT_REASON = page_mgmt_pkg::conflict_exit_reason_default
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             op_busy,
  output page_mgmt_pkg::outcome_t op_outcome
);
  import page_mgmt_pkg::*;

  localparam int unsigned IDX_W = (PAGES > 1) ? $clog2(PAGES) : 1;

  typedef struct packed {
    page_meta_t [PAGES-1:0] meta;
    op_state_t              state;
    logic [31:0]            leaf;
    logic [31:0]            operand;
    logic [3:0]             mode;
    logic [IDX_W-1:0]       page_sel;
    logic [31:0]            result;
    op_flags_t              flags;
    outcome_t               outcome;
    logic [31:0]            fault_addr;
    logic [15:0]            exit_reason;
    logic [15:0]            exit_qual;
    logic [31:0]            exit_gpa;
    logic [31:0]            exit_gla;
    logic [31:0]            rdata;
    logic                   slverr;
  } state_t;

  state_t cur;
  state_t next_cur;

  function automatic logic in_cache(input logic [31:0] addr);
    logic [31:0] span;
    span = 32'(PAGES) << page_offset_bits;
    return (addr >= CACHE_BASE) && ((addr - CACHE_BASE) < span);
  endfunction

  function automatic logic [IDX_W-1:0] page_idx(input logic [31:0] addr);
    logic [31:0] rel;
    rel = (addr - CACHE_BASE) >> page_offset_bits;
    return rel[IDX_W-1:0];
  endfunction

  function automatic logic [31:0] page_addr(input logic [IDX_W-1:0] idx);
    return CACHE_BASE + (32'(idx) << page_offset_bits);
  endfunction

  function automatic logic is_child_type(input logic [2:0] t);
    return (t == regular_page_type) || (t == thread_control_type) ||
           (t == trimmed_type) || (t == shadow_stack_first_type) ||
           (t == shadow_stack_rest_type);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a <= off_page_data) && (a[1:0] == 2'b00);
  endfunction

  // Zero wait states: every access finishes in its first access cycle
  assign pready     = 1'b1;
  assign prdata     = cur.rdata;
  assign pslverr    = cur.slverr;
  assign op_busy    = (cur.state == st_exec);
  assign op_outcome = cur.outcome;

  always_comb begin
    logic             setup;
    logic             wr;
    logic [7:0]       a;
    logic             guest_virt;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] par;
    page_meta_t       m;
    page_meta_t       pm;
    setup      = 1'b0;
    wr         = 1'b0;
    a          = 8'h00;
    guest_virt = 1'b0;
    idx        = '0;
    par        = '0;
    m          = meta_reset;
    pm         = meta_reset;
    next_cur   = cur;

    setup = psel && !penable;
    wr    = psel && penable && pwrite;
    a     = paddr[7:0];

    // Read data is captured in the setup cycle so it comes from a flip-flop
    if (setup) begin
      next_cur.slverr = !mapped(a) || (paddr[31:8] != 24'h00_0000);
      next_cur.rdata  = 32'h0000_0000;
      if (!pwrite && !next_cur.slverr) begin
        unique case (a)
          off_leaf:       next_cur.rdata = cur.leaf;
          off_operand:    next_cur.rdata = cur.operand;
          off_mode:       next_cur.rdata = {28'h000_0000, cur.mode};
          off_result:     next_cur.rdata = cur.result;
          off_status:     next_cur.rdata = {15'h0000, op_busy, 5'h00, cur.outcome,
                                            2'b00, cur.flags};
          off_fault_addr: next_cur.rdata = cur.fault_addr;
          off_exit_info:  next_cur.rdata = {cur.exit_reason, cur.exit_qual};
          off_exit_gpa:   next_cur.rdata = cur.exit_gpa;
          off_exit_gla:   next_cur.rdata = cur.exit_gla;
          off_page_sel:   next_cur.rdata = 32'(cur.page_sel);
          off_page_data:  next_cur.rdata = cur.meta[cur.page_sel];
          default:        next_cur.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Writes take effect at the access edge; any nonzero strobe writes the whole word
    if (wr && !cur.slverr && (pstrb != 4'h0)) begin
      unique case (a)
        off_leaf:      next_cur.leaf     = pwdata;
        off_operand:   next_cur.operand  = pwdata;
        off_mode:      next_cur.mode     = pwdata[3:0];
        off_page_sel:  next_cur.page_sel = pwdata[IDX_W-1:0];
        off_page_data: next_cur.meta[cur.page_sel] = pwdata;
        off_start: begin
          // A start while an operation runs is dropped
          if (cur.state == st_idle) begin
            next_cur.state   = st_exec;
            next_cur.outcome = out_none;
          end
        end
        default: ;
      endcase
    end

    if (cur.state == st_exec) begin
      next_cur.state = st_idle;
      guest_virt     = cur.mode[mode_guest_bit] && cur.mode[mode_virt_bit];
      idx            = page_idx(cur.operand);
      m              = cur.meta[idx];
      par            = m.parent[IDX_W-1:0];
      pm             = cur.meta[par];
      if ((cur.leaf != leaf_page_remove) && (cur.leaf != leaf_tracking_start)) begin
        next_cur.outcome = out_gp;
      end else if (cur.mode[mode_cpl_lsb +: 2] != 2'b00) begin
        next_cur.outcome = out_gp;
      end else if (cur.operand[page_offset_bits-1:0] != '0) begin
        next_cur.outcome = out_gp;
      end else if (!in_cache(cur.operand)) begin
        next_cur.outcome    = out_pf;
        next_cur.fault_addr = cur.operand;
      end else if (cur.leaf == leaf_page_remove) begin
        // Only the page hold is checked; other operation kinds run alongside
        if (m.in_use) begin
          if (guest_virt) begin
            next_cur.outcome     = out_vmexit;
            next_cur.exit_reason = CONFLICT_EXIT_REASON;
            next_cur.exit_qual   = page_conflict_qualifier;
            next_cur.exit_gpa    = cur.operand;
            next_cur.exit_gla    = cur.operand;
          end else begin
            next_cur.outcome = out_gp;
          end
        end else begin
          next_cur.outcome = out_done;
          next_cur.flags   = flags_reset;
          next_cur.result  = code_success;
          if (!m.valid || (m.ptype == trimmed_type && !m.modified)) begin
            // Already unused, nothing to change
          end else if (m.ptype == version_array_type) begin
            // Unmodified trimmed pages were already taken above
            next_cur.meta[idx].valid = 1'b0;
          end else if (m.ptype == control_structure_type) begin
            if ((m.child_count != 8'h00) ||
                (guest_virt && m.virtual_child_count != 8'h00)) begin
              next_cur.flags.zero_flag = 1'b1;
              next_cur.result          = CHILD_PRESENT_CODE;
            end else begin
              next_cur.meta[idx].valid = 1'b0;
            end
          end else if (pm.threads_active) begin
            next_cur.flags.zero_flag = 1'b1;
            next_cur.result          = ENCLAVE_ACTIVE_CODE;
          end else if (is_child_type(m.ptype)) begin
            next_cur.meta[idx].valid = 1'b0;
            // Parent forgets the child so it can be removed later
            if (pm.child_count != 8'h00) begin
              next_cur.meta[par].child_count = pm.child_count - 8'h01;
            end
          end
        end
      end else begin
        // Shared on the structure: only the tracking lock is exclusive
        if (m.track_lock) begin
          if (guest_virt) begin
            next_cur.outcome     = out_vmexit;
            next_cur.exit_reason = CONFLICT_EXIT_REASON;
            next_cur.exit_qual   = resource_conflict_qualifier;
            next_cur.exit_gpa    = page_addr(idx);
            next_cur.exit_gla    = 32'h0000_0000;
          end else begin
            next_cur.outcome = out_gp;
          end
        end else if (!m.valid || m.ptype != control_structure_type) begin
          next_cur.outcome    = out_pf;
          next_cur.fault_addr = cur.operand;
        end else begin
          next_cur.flags  = flags_reset;
          next_cur.result = code_success;
          if (m.tracking) begin
            next_cur.flags.zero_flag = 1'b1;
            next_cur.result          = previous_tracking_incomplete_code;
            next_cur.outcome         = out_done;
            if (guest_virt) begin
              next_cur.outcome     = out_vmexit;
              next_cur.exit_reason = CONFLICT_EXIT_REASON;
              next_cur.exit_qual   = reference_conflict_qualifier;
              next_cur.exit_gpa    = page_addr(idx);
              next_cur.exit_gla    = 32'h0000_0000;
            end
          end else begin
            next_cur.outcome              = out_done;
            next_cur.meta[idx].tracking   = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

endmodule // protected_page_remove_and_track

/* File: pkg/page_mgmt_pkg.sv */
// Constants and types shared by the protected page removal and tracking block
package page_mgmt_pkg;

  // Register byte offsets
  localparam logic [7:0] off_leaf       = 8'h00;
  localparam logic [7:0] off_operand    = 8'h04;
  localparam logic [7:0] off_mode       = 8'h08;
  localparam logic [7:0] off_start      = 8'h0c;
  localparam logic [7:0] off_result     = 8'h10;
  localparam logic [7:0] off_status     = 8'h14;
  localparam logic [7:0] off_fault_addr = 8'h18;
  localparam logic [7:0] off_exit_info  = 8'h1c;
  localparam logic [7:0] off_exit_gpa   = 8'h20;
  localparam logic [7:0] off_exit_gla   = 8'h24;
  localparam logic [7:0] off_page_sel   = 8'h28;
  localparam logic [7:0] off_page_data  = 8'h2c;

  // Leaf selector values
  localparam logic [31:0] leaf_page_remove    = 32'h0000_0003;
  localparam logic [31:0] leaf_tracking_start = 32'h0000_000c;

  // Result codes
  localparam logic [31:0] code_success                      = 32'h0000_0000;
  localparam logic [31:0] child_present_code_default        = 32'h0000_0001;
  localparam logic [31:0] enclave_active_code_default       = 32'h0000_0002;
  localparam logic [31:0] previous_tracking_incomplete_code = 32'h0000_0011;

  // Exit reason and qualification values
  localparam logic [15:0] conflict_exit_reason_default = 16'h0001;
  localparam logic [15:0] page_conflict_qualifier      = 16'h0001;
  localparam logic [15:0] resource_conflict_qualifier  = 16'h0002;
  localparam logic [15:0] reference_conflict_qualifier = 16'h0003;

  // Page geometry
  localparam int unsigned page_offset_bits = 12;
  localparam logic [31:0] cache_base_default = 32'h0010_0000;

  // Mode register fields
  localparam int unsigned mode_cpl_lsb   = 0;
  localparam int unsigned mode_guest_bit = 2;
  localparam int unsigned mode_virt_bit  = 3;

  // Status register fields
  localparam int unsigned status_outcome_lsb = 8;
  localparam int unsigned status_busy_bit    = 16;

  // Page types
  localparam logic [2:0] control_structure_type  = 3'h0;
  localparam logic [2:0] thread_control_type     = 3'h1;
  localparam logic [2:0] regular_page_type       = 3'h2;
  localparam logic [2:0] version_array_type      = 3'h3;
  localparam logic [2:0] trimmed_type            = 3'h4;
  localparam logic [2:0] shadow_stack_first_type = 3'h5;
  localparam logic [2:0] shadow_stack_rest_type  = 3'h6;

  typedef enum logic [2:0] {
    out_none   = 3'b000,
    out_done   = 3'b001,
    out_gp     = 3'b010,
    out_pf     = 3'b011,
    out_vmexit = 3'b100
  } outcome_t;

  typedef enum logic {
    st_idle = 1'b0,
    st_exec = 1'b1
  } op_state_t;

  // One word of the page metadata map
  typedef struct packed {
    logic [7:0] virtual_child_count;
    logic [7:0] child_count;
    logic [3:0] parent;
    logic [2:0] rsvd;
    logic       threads_active;
    logic       tracking;
    logic       track_lock;
    logic       in_use;
    logic       modified;
    logic [2:0] ptype;
    logic       valid;
  } page_meta_t;

  typedef struct packed {
    logic zero_flag;
    logic carry_flag;
    logic parity_flag;
    logic adjust_flag;
    logic overflow_flag;
    logic sign_flag;
  } op_flags_t;

  localparam page_meta_t meta_reset  = '0;
  localparam op_flags_t  flags_reset = '0;

endpackage

/* File: tb/page_ops_checker.sv */
// Port-level checks for the page removal and tracking block
`timescale 1ns/10ps
module page_ops_checker
  import page_mgmt_pkg::*;
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    ce,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             paddr,
  input wire logic [3:0]              pstrb,
  input wire logic                    pready,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  input wire logic                    op_busy,
  input wire page_mgmt_pkg::outcome_t op_outcome
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic st_wr;
  logic bad;
  assign st_wr = psel && penable && pwrite && paddr == {24'h0, off_start};
  assign bad = paddr[31:8] != 24'h0 || paddr[7:0] > off_page_data || paddr[1:0] != 2'h0;
  // Start taken only while idle; a busy write is dropped
  sequence s_start;
    ce && st_wr && !op_busy && pstrb != 4'h0;
  endsequence
  sequence s_exec;
    op_busy ##1 (!op_busy && op_outcome != out_none);
  endsequence
  a_ready_always: assert property (pready) else $error("pready low");
  a_start_exec: assert property (s_start |=> s_exec)
    else $error("start did not run one step");
  a_busy_single: assert property (ce && op_busy |=> !op_busy)
    else $error("busy longer than one cycle");
  a_busy_cause: assert property ($rose(op_busy) |-> $past(st_wr))
    else $error("busy without start");
  a_outcome_hold: assert property (!op_busy ##1 !op_busy |-> $stable(op_outcome))
    else $error("outcome moved while idle");
  a_err_unmapped: assert property (psel && !penable && ce && bad |=> pslverr)
    else $error("no slave error");
  a_err_mapped: assert property (psel && !penable && ce && !bad |=> !pslverr)
    else $error("spurious slave error");
  a_read_unmapped: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // page_ops_checker

bind protected_page_remove_and_track page_ops_checker u_chk (.pclk, .presetn, .ce, .psel,
  .penable, .pwrite, .paddr, .pstrb, .pready, .prdata, .pslverr, .op_busy, .op_outcome);

/* File: tb/sys_sw.sv */
// Software side model issuing APB transfers to the block
`timescale 1ns/10ps
module sys_sw (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  output logic             hung
);
  assign pstrb = 4'hf;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    hung = hung | (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines do not keep the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // sys_sw

/* File: tb/tb_protected_page_remove_and_track.sv */
// Self-checking bench for page removal and tracking
`timescale 1ns/10ps
module tb_protected_page_remove_and_track;
  import page_mgmt_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        ce;
  logic        psel, penable, pwrite, pready, pslverr, op_busy;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  outcome_t    op_outcome;
  int          errors = 0;
  int          cmp_count = 0;
  localparam logic [31:0] rsn = {16'h0, conflict_exit_reason_default} << 16;

  always #4 pclk = ~pclk;

  protected_page_remove_and_track u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .op_busy, .op_outcome);
  sys_sw u_sw (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .hung());

  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_sw.xfer(1'b1, {24'h0, a}, d, q);
    if (u_sw.hung === 1'b1) begin
      errors++;
      final_report();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    u_sw.xfer(1'b0, {24'h0, a}, 32'h0, q);
    if (u_sw.hung === 1'b1) begin
      errors++;
      final_report();
    end
  endtask
  function automatic logic [31:0] pa(input int i);
    return cache_base_default + 32'(i) * 32'h1000;
  endfunction
  task automatic setp(input int i, input logic [31:0] m);
    wr(off_page_sel, 32'(i));
    wr(off_page_data, m);
  endtask
  task automatic pagechk(input int i, input logic [31:0] e);
    logic [31:0] q;
    wr(off_page_sel, 32'(i));
    rd(off_page_data, q);
    chk(q, e);
  endtask
  // Flags and result only judged on normal completion; gp and pf faults keep the old ones
  task automatic op(input logic [31:0] leaf, a, mode, input logic [2:0] out,
                    input logic [31:0] res, input logic zf);
    logic [31:0] q;
    int n;
    n = 0;
    wr(off_leaf, leaf);
    wr(off_operand, a);
    wr(off_mode, mode);
    wr(off_start, 32'h1);
    while (op_busy !== 1'b1 && n < 10) begin
      @(negedge pclk);
      n++;
    end
    if (op_busy !== 1'b1) begin
      errors++;
      final_report();
    end
    rd(off_status, q);
    if (out != out_done) q = q & 32'h0001_0700;
    chk(q, {21'h0, out, 2'h0, zf, 5'h0});
    chk({29'h0, op_outcome}, {29'h0, out});
    if (out == out_done) begin
      rd(off_result, q);
      chk(q, res);
    end
  endtask
  task automatic exitchk(input logic [31:0] info, gpa, gla);
    logic [31:0] q;
    rd(off_exit_info, q);
    chk(q, info);
    rd(off_exit_gpa, q);
    chk(q, gpa);
    rd(off_exit_gla, q);
    chk(q, gla);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    for (int a = 0; a <= 'h30; a += 4) begin
      if (a != 'h0c) begin
        rd(8'(a), q);
        chk(q, 32'h0);
      end
    end
    // Last read hit the unmapped word above the map
    chk({31'h0, pslverr}, 32'h1);
  endtask
  task automatic t_remove_types();
    logic [2:0] ty [6] = '{thread_control_type, regular_page_type, trimmed_type,
      shadow_stack_first_type, shadow_stack_rest_type, version_array_type};
    foreach (ty[k]) begin
      setp(0, 32'h1);
      setp(1, {27'h0, 1'b1, ty[k], 1'b1});
      op(leaf_page_remove, pa(1), 32'h0, out_done, code_success, 1'b0);
      pagechk(1, {27'h0, 1'b1, ty[k], 1'b0});
    end
  endtask
  task automatic t_remove_errors();
    setp(0, 32'h0001_0001);
    op(leaf_page_remove, pa(0), 32'h0, out_done, child_present_code_default, 1'b1);
    pagechk(0, 32'h0001_0001);
    setp(0, 32'h0100_0001);
    op(leaf_page_remove, pa(0), 32'hc, out_done, child_present_code_default, 1'b1);
    op(leaf_page_remove, pa(0), 32'h0, out_done, code_success, 1'b0);
    pagechk(0, 32'h0100_0000);
    setp(0, 32'h0000_0101);
    setp(1, 32'h0000_0105);
    op(leaf_page_remove, pa(1), 32'h0, out_done, enclave_active_code_default, 1'b1);
    pagechk(1, 32'h0000_0105);
    setp(2, 32'h0000_0004);
    op(leaf_page_remove, pa(2), 32'h0, out_done, code_success, 1'b0);
    pagechk(2, 32'h0000_0004);
    setp(2, 32'h0000_0009);
    op(leaf_page_remove, pa(2), 32'h0, out_done, code_success, 1'b0);
    pagechk(2, 32'h0000_0009);
  endtask
  task automatic t_faults();
    logic [31:0] q;
    setp(3, 32'h0000_0025);
    op(leaf_page_remove, pa(3) + 32'h4, 32'h0, out_gp, 32'h0, 1'b0);
    op(leaf_tracking_start, pa(16) + 32'h8, 32'h0, out_gp, 32'h0, 1'b0);
    op(leaf_page_remove, pa(16), 32'h0, out_pf, 32'h0, 1'b0);
    rd(off_fault_addr, q);
    chk(q, pa(16));
    op(leaf_page_remove, pa(3), 32'h0, out_gp, 32'h0, 1'b0);
    op(leaf_page_remove, pa(3), 32'hc, out_vmexit, 32'h0, 1'b0);
    exitchk(rsn | 32'(page_conflict_qualifier), pa(3), pa(3));
    pagechk(3, 32'h0000_0025);
  endtask
  task automatic t_track();
    setp(4, 32'h1);
    setp(5, 32'h0000_0021);
    op(leaf_tracking_start, pa(4), 32'h3, out_gp, 32'h0, 1'b0);
    op(leaf_tracking_start, pa(4), 32'h0, out_done, code_success, 1'b0);
    pagechk(4, 32'h0000_0081);
    op(leaf_tracking_start, pa(4), 32'h0, out_done, 32'd17, 1'b1);
    op(leaf_tracking_start, pa(4), 32'hc, out_vmexit, 32'h0, 1'b0);
    exitchk(rsn | 32'(reference_conflict_qualifier), pa(4), 32'h0);
    op(leaf_tracking_start, pa(5), 32'h0, out_done, code_success, 1'b0);
    setp(5, 32'h0000_0041);
    op(leaf_tracking_start, pa(5), 32'h0, out_gp, 32'h0, 1'b0);
    op(leaf_tracking_start, pa(5), 32'hc, out_vmexit, 32'h0, 1'b0);
    exitchk(rsn | 32'(resource_conflict_qualifier), pa(5), 32'h0);
    setp(6, 32'h0);
    op(leaf_tracking_start, pa(6), 32'h0, out_pf, 32'h0, 1'b0);
    setp(6, 32'h0000_0005);
    op(leaf_tracking_start, pa(6), 32'h0, out_pf, 32'h0, 1'b0);
  endtask

  task automatic final_report();
    if (errors == 0 && cmp_count > 0 && u_sw.hung !== 1'b1) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_remove_types();
    t_remove_errors();
    t_faults();
    t_track();
    final_report();
  end
endmodule // tb_protected_page_remove_and_track
